// File: src/ddpu_consts.svh
// Constants of the dual data pointer unit: offsets, fields, reset values
//
// Function
// RULE_01 - Main and shadow 16-bit pointers, control at A7
// RULE_02 - Instructions always use the active pointer
// RULE_03 - Only pointer-indirect moves modify pointers
// RULE_04 - Auto-toggle bit 6 swaps active pointer
// RULE_05 - Shadow mode 00 standard, 01 post-increment
// RULE_06 - Shadow mode 10 post-decrements shadow pointer
// RULE_07 - Shadow mode 11 inverts shadow pointer LSB
// RULE_08 - Bits 3:2 hold the main pointer mode
// RULE_09 - Bit 7 unimplemented, reads zero
// RULE_10 - Main mode uses same four encodings
// RULE_11 - Select bit 0 maps main or shadow
// RULE_12 - Bit 1 unimplemented, reads zero
// RULE_13 - Wrap modulo 2^16; modify, then flip select
`ifndef DDPU_CONSTS_SVH
`define DDPU_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define DDPU_IDX_CTRL 8'hA7
`define DDPU_IDX_PLOW 8'h00
`define DDPU_IDX_PHIGH 8'h01
`define DDPU_ADDR_W 10
`define DDPU_IDX_MSB 9
`define DDPU_IDX_LSB 2
`define DDPU_ALIGN_ZERO 2'h0

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define DDPU_BIT_SEL 0
`define DDPU_BIT_TGL 6
`define DDPU_BIT_UNIMP_LO 1
`define DDPU_BIT_UNIMP_HI 7
`define DDPU_MAIN_MSB 3
`define DDPU_MAIN_LSB 2
`define DDPU_SHAD_MSB 5
`define DDPU_SHAD_LSB 4
`define DDPU_CTRL_WMASK 8'h7D
`define DDPU_CTRL_RST 8'h00
`define DDPU_PTR_RST 16'h0000
`define DDPU_PTR_STEP 16'h0001
`define DDPU_RDATA_RST 32'h00000000
`define DDPU_RD_PAD 24'h000000
`define DDPU_BYTE_ZERO 8'h00
`define DDPU_BE_LANE0 0

`endif

// File: src/ddpu_pkg.sv
// Types of the dual data pointer unit
package ddpu_pkg;

    // ------------------------------------------------------------
    // Pointer modification modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STD = 2'h0,
        MODE_INC = 2'h1,
        MODE_DEC = 2'h2,
        MODE_TGL = 2'h3
    } ddpu_mode_t;

    // ------------------------------------------------------------
    // Move kinds reported by the core
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MV_PTR_XDATA = 2'h0,
        MV_PTR_CODE = 2'h1,
        MV_PC_CODE = 2'h2,
        MV_REG_XDATA = 2'h3
    } ddpu_move_kind_t;

    typedef struct packed {
        logic valid;
        ddpu_move_kind_t kind;
    } ddpu_move_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } ddpu_load_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [9:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } ddpu_avs_req_t;

    // ------------------------------------------------------------
    // Bus answer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_ACK = 2'h2
    } ddpu_bus_st_t;

endpackage

// File: src/ddpu_ptr_step.sv
// Post-move modification of one 16-bit pointer
`timescale 1ns/100ps
`include "ddpu_consts.svh"

module ddpu_ptr_step (
    input wire logic [15:0] ptr,
    input wire ddpu_pkg::ddpu_mode_t mode,
    output logic [15:0] next_ptr
);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        case (mode)
            ddpu_pkg::MODE_STD: begin
                next_ptr = ptr;
            end
            ddpu_pkg::MODE_INC: begin
                next_ptr = 16'(ptr + `DDPU_PTR_STEP); // RULE_05 RULE_13
            end
            ddpu_pkg::MODE_DEC: begin
                next_ptr = 16'(ptr - `DDPU_PTR_STEP); // RULE_06 RULE_13
            end
            ddpu_pkg::MODE_TGL: begin
                next_ptr = {ptr[15:1], ~ptr[0]}; // RULE_07
            end
            default: begin
                next_ptr = ptr;
            end
        endcase
    end

endmodule // ddpu_ptr_step

// File: src/ddpu_top.sv
// Dual data pointer unit with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "ddpu_consts.svh"

module ddpu_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire ddpu_pkg::ddpu_avs_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire ddpu_pkg::ddpu_move_t core_move,
    input wire ddpu_pkg::ddpu_load_t core_load,
    output logic [15:0] active_pointer,
    output logic pointer_select
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [15:0] main_q;
    logic [15:0] main_d;
    logic [15:0] shad_q;
    logic [15:0] shad_d;
    logic [15:0] act_q;
    logic [15:0] act_d;
    ddpu_pkg::ddpu_bus_st_t bus_st_q;
    ddpu_pkg::ddpu_bus_st_t bus_st_d;
    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // ------------------------------------------------------------
    // Decoded control fields
    // ------------------------------------------------------------
    logic sel;
    logic tgl;
    ddpu_pkg::ddpu_mode_t main_mode;
    ddpu_pkg::ddpu_mode_t shad_mode;
    logic [15:0] main_step;
    logic [15:0] shad_step;
    logic qualify;

    assign sel = ctrl_q[`DDPU_BIT_SEL];
    assign tgl = ctrl_q[`DDPU_BIT_TGL];
    assign main_mode = ddpu_pkg::ddpu_mode_t'(ctrl_q[`DDPU_MAIN_MSB:`DDPU_MAIN_LSB]); // RULE_08
    assign shad_mode = ddpu_pkg::ddpu_mode_t'(ctrl_q[`DDPU_SHAD_MSB:`DDPU_SHAD_LSB]);

    // PC-relative and register-indirect moves never qualify
    assign qualify = core_move.valid &&
        (core_move.kind == ddpu_pkg::MV_PTR_XDATA ||
         core_move.kind == ddpu_pkg::MV_PTR_CODE); // RULE_03

    // ------------------------------------------------------------
    // Per-pointer modifiers
    // ------------------------------------------------------------
    ddpu_ptr_step u_main_step (
        .ptr(main_q),
        .mode(main_mode),
        .next_ptr(main_step)
    ); // RULE_10

    ddpu_ptr_step u_shad_step (
        .ptr(shad_q),
        .mode(shad_mode),
        .next_ptr(shad_step)
    ); // RULE_05

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [7:0] idx;
    logic aligned;
    logic accept;
    logic wr_acc;
    logic wr_ctrl;
    logic wr_plow;
    logic wr_phigh;
    logic wr_ptr;
    logic [7:0] wbyte;

    assign idx = avs_req.address[`DDPU_IDX_MSB:`DDPU_IDX_LSB];
    assign aligned = avs_req.address[`DDPU_IDX_LSB - 1:0] == `DDPU_ALIGN_ZERO;
    assign accept = bus_st_q == ddpu_pkg::ST_ACK;
    // Only lane 0 carries register data; other lanes are ignored
    assign wr_acc = accept && avs_req.write && aligned &&
        avs_req.byteenable[`DDPU_BE_LANE0];
    assign wr_ctrl = wr_acc && idx == `DDPU_IDX_CTRL; // RULE_01
    assign wr_plow = wr_acc && idx == `DDPU_IDX_PLOW;
    assign wr_phigh = wr_acc && idx == `DDPU_IDX_PHIGH;
    assign wr_ptr = wr_plow || wr_phigh;
    assign wbyte = avs_req.writedata[7:0];

    // ------------------------------------------------------------
    // Pointer and control next state
    // ------------------------------------------------------------
    always_comb begin
        main_d = main_q;
        shad_d = shad_q;
        ctrl_d = ctrl_q;
        // Modify the pointer just used first
        if (qualify) begin
            if (sel) begin
                shad_d = shad_step; // RULE_02
            end else begin
                main_d = main_step; // RULE_02
            end
            if (tgl) begin
                ctrl_d[`DDPU_BIT_SEL] = ~sel; // RULE_04
            end
        end
        // A core load overrides the move on the same pointer
        if (core_load.valid) begin
            if (sel) begin
                shad_d = core_load.data; // RULE_02
            end else begin
                main_d = core_load.data; // RULE_02
            end
        end
        // Software byte writes land on the pointer active now
        if (wr_plow) begin
            if (sel) begin
                shad_d[7:0] = wbyte; // RULE_11
            end else begin
                main_d[7:0] = wbyte; // RULE_11
            end
        end
        if (wr_phigh) begin
            if (sel) begin
                shad_d[15:8] = wbyte; // RULE_11
            end else begin
                main_d[15:8] = wbyte; // RULE_11
            end
        end
        // Software write beats the auto-toggle; bits 7 and 1 drop
        if (wr_ctrl) begin
            ctrl_d = wbyte & `DDPU_CTRL_WMASK; // RULE_09 RULE_12
        end
        // Select applied after the modification
        act_d = ctrl_d[`DDPU_BIT_SEL] ? shad_d : main_d; // RULE_13
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= `DDPU_CTRL_RST;
            main_q <= `DDPU_PTR_RST;
            shad_q <= `DDPU_PTR_RST;
            act_q <= `DDPU_PTR_RST;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            main_q <= main_d;
            shad_q <= shad_d;
            act_q <= act_d;
        end
    end

    // ------------------------------------------------------------
    // Bus answer machine
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        bus_st_d = bus_st_q;
        rdata_d = rdata_q;
        rd_byte = `DDPU_BYTE_ZERO;
        if (aligned) begin
            case (idx)
                `DDPU_IDX_CTRL: begin
                    rd_byte = ctrl_q;
                end
                `DDPU_IDX_PLOW: begin
                    rd_byte = act_q[7:0];
                end
                `DDPU_IDX_PHIGH: begin
                    rd_byte = act_q[15:8];
                end
                default: begin
                    rd_byte = `DDPU_BYTE_ZERO;
                end
            endcase
        end
        case (bus_st_q)
            ddpu_pkg::ST_IDLE: begin
                if (avs_req.read || avs_req.write) begin
                    bus_st_d = ddpu_pkg::ST_ACK;
                end
                // Captured one cycle early so the answer is a flip-flop
                if (avs_req.read) begin
                    rdata_d = {`DDPU_RD_PAD, rd_byte};
                end
            end
            ddpu_pkg::ST_ACK: begin
                bus_st_d = ddpu_pkg::ST_IDLE;
            end
            default: begin
                bus_st_d = ddpu_pkg::ST_IDLE;
            end
        endcase
        wait_d = bus_st_d != ddpu_pkg::ST_ACK;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_st_q <= ddpu_pkg::ST_IDLE;
            wait_q <= 1'b1;
            rdata_q <= `DDPU_RDATA_RST;
        end else if (ce) begin
            bus_st_q <= bus_st_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign active_pointer = act_q;
    assign pointer_select = ctrl_q[`DDPU_BIT_SEL];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic mv_only;
    logic other_mv;

    // A move with no competing load or pointer byte write in the same cycle; a control write may still occur
    assign mv_only = ce && qualify && !core_load.valid && !wr_ptr;
    assign other_mv = ce && core_move.valid && !qualify && !core_load.valid && !wr_ptr;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_main_inc_step: assert property ( // RULE_10
        mv_only && !sel && main_mode == ddpu_pkg::MODE_INC
        |=> main_q == 16'($past(main_q) + `DDPU_PTR_STEP) && shad_q == $past(shad_q))
        else $error("Main pointer did not post-increment");

    a_shad_inc_step: assert property ( // RULE_05
        mv_only && sel && shad_mode == ddpu_pkg::MODE_INC
        |=> shad_q == 16'($past(shad_q) + `DDPU_PTR_STEP) && main_q == $past(main_q))
        else $error("Shadow pointer did not post-increment");

    a_shad_dec_step: assert property ( // RULE_06
        mv_only && sel && shad_mode == ddpu_pkg::MODE_DEC
        |=> shad_q == 16'($past(shad_q) - `DDPU_PTR_STEP))
        else $error("Shadow pointer did not post-decrement");

    a_shad_lsb_flip: assert property ( // RULE_07
        mv_only && sel && shad_mode == ddpu_pkg::MODE_TGL
        |=> shad_q[15:1] == $past(shad_q[15:1]) && shad_q[0] != $past(shad_q[0]))
        else $error("Shadow pointer LSB toggle wrong");

    a_std_mode_hold: assert property ( // RULE_05
        mv_only && sel && shad_mode == ddpu_pkg::MODE_STD
        |=> $stable(shad_q) && $stable(main_q))
        else $error("Standard mode changed a pointer");

    a_other_move_hold: assert property ( // RULE_03
        other_mv |=> $stable(main_q) && $stable(shad_q))
        else $error("Non-pointer move changed a pointer");

    a_auto_swap: assert property ( // RULE_04
        ce && qualify && tgl && !wr_ctrl |=> pointer_select != $past(pointer_select))
        else $error("Auto-toggle did not swap pointer");

    a_no_swap: assert property ( // RULE_04
        ce && qualify && !tgl && !wr_ctrl |=> $stable(pointer_select))
        else $error("Pointer swapped with auto-toggle off");

    a_main_dec_step: assert property ( // RULE_10
        mv_only && !sel && main_mode == ddpu_pkg::MODE_DEC
        |=> main_q == 16'($past(main_q) - `DDPU_PTR_STEP) && shad_q == $past(shad_q))
        else $error("Main pointer did not post-decrement");

    a_main_lsb_flip: assert property ( // RULE_10
        mv_only && !sel && main_mode == ddpu_pkg::MODE_TGL
        |=> main_q[15:1] == $past(main_q[15:1]) && main_q[0] != $past(main_q[0]))
        else $error("Main pointer LSB toggle wrong");

    a_main_std_hold: assert property ( // RULE_10
        mv_only && !sel && main_mode == ddpu_pkg::MODE_STD
        |=> $stable(main_q) && $stable(shad_q))
        else $error("Standard mode changed the main pointer");

    a_bit7_zero: assert property ( // RULE_09
        ctrl_q[`DDPU_BIT_UNIMP_HI] == 1'b0)
        else $error("Unimplemented bit 7 set");

    a_bit1_zero: assert property ( // RULE_12
        ctrl_q[`DDPU_BIT_UNIMP_LO] == 1'b0)
        else $error("Unimplemented bit 1 set");

    a_active_mux: assert property ( // RULE_11
        active_pointer == (pointer_select ? shad_q : main_q))
        else $error("Active pointer does not follow select");

    a_bus_answer: assert property ( // RULE_01
        ce && bus_st_q == ddpu_pkg::ST_IDLE && (avs_req.read || avs_req.write)
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Bus answer timing wrong");

endmodule // ddpu_top

// File: verification/ddpu_core_model.sv
// Core-side model that issues move and load pulses to the pointer unit
`timescale 1ns/100ps

module ddpu_core_model (
    input wire logic ref_clk,
    output ddpu_pkg::ddpu_move_t core_move,
    output ddpu_pkg::ddpu_load_t core_load
);
    initial begin
        core_move = '0;
        core_load = '0;
    end

    // ------------------------------------------------------------
    // One-cycle pulses
    // ------------------------------------------------------------
    // Idle lines show the inverse, so a stale value never passes as fresh
    task automatic move(input logic [1:0] k);
        @(posedge ref_clk);
        core_move <= '{valid: 1'b1, kind: ddpu_pkg::ddpu_move_kind_t'(k)};
        @(posedge ref_clk);
        core_move <= '{valid: 1'b0, kind: ddpu_pkg::ddpu_move_kind_t'(~k)};
    endtask

    task automatic load(input logic [15:0] d);
        @(posedge ref_clk);
        core_load <= '{valid: 1'b1, data: d};
        @(posedge ref_clk);
        core_load <= '{valid: 1'b0, data: ~d};
    endtask
endmodule // ddpu_core_model

// File: verification/dual_data_pointer_unit_tb.sv
// Self-checking bench of the dual data pointer unit
`timescale 1ns/100ps

module dual_data_pointer_unit_tb;
    localparam logic [9:0] A_CTL = 10'h29C;
    localparam logic [9:0] A_LO = 10'h000;
    localparam logic [9:0] A_HI = 10'h004;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    ddpu_pkg::ddpu_avs_req_t avs_req = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    ddpu_pkg::ddpu_move_t core_move;
    ddpu_pkg::ddpu_load_t core_load;
    logic [15:0] active_pointer;
    logic pointer_select;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    logic [31:0] exp_q[$];
    logic [7:0] ctl;
    logic [7:0] c;
    logic [15:0] mp;
    logic [15:0] sp;
    logic [1:0] k;

    always #4 ref_clk = ~ref_clk;

    ddpu_top u_ddpu_top (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .avs_req(avs_req),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .core_move(core_move),
        .core_load(core_load),
        .active_pointer(active_pointer),
        .pointer_select(pointer_select)
    );

    ddpu_core_model u_ddpu_core_model (
        .ref_clk(ref_clk),
        .core_move(core_move),
        .core_load(core_load)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Read data taken at the edge where waitrequest is seen low
    always @(posedge ref_clk) begin
        if (avs_req.read && avs_waitrequest === 1'b0) begin
            chk(avs_readdata, exp_q.pop_front());
        end
    end

    // Whole run needs about 1200 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Bus master and reference
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd);
        @(posedge ref_clk);
        avs_req <= '{read: !wr, write: wr, address: a, writedata: {24'h000000, wd},
                     byteenable: 4'hF};
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_req <= '0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        bus(1'b0, a, 8'h00);
    endtask

    function automatic logic [15:0] step(input logic [15:0] p, input logic [1:0] m);
        case (m)
            2'h1: step = p + 16'h0001;
            2'h2: step = p - 16'h0001;
            2'h3: step = p ^ 16'h0001;
            default: step = p;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(21));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk(32'(active_pointer), 32'h00000000);
        chk(32'(pointer_select), 32'h00000000);
        rd(A_CTL, 8'h00);
        rd(A_LO, 8'h00);
        rd(A_HI, 8'h00);
        rd(10'h010, 8'h00);
        bus(1'b1, A_CTL, 8'hFF);
        rd(A_CTL, 8'h7D);
        // Misaligned accesses are refused: write dropped, read gives zero
        bus(1'b1, 10'h29E, 8'h00);
        rd(A_CTL, 8'h7D);
        rd(10'h29D, 8'h00);
        for (int i = 0; i < 48; i++) begin
            mp = (i % 3 == 0) ? 16'hFFFF : 16'($urandom);
            sp = (i % 3 == 0) ? 16'h0000 : 16'($urandom);
            c = 8'($urandom);
            k = (i < 32) ? 2'($urandom % 2) : 2'($urandom);
            if (i < 32) begin
                c[5:2] = 4'(i);
                c[0] = i[4];
            end
            bus(1'b1, A_CTL, 8'h00);
            u_ddpu_core_model.load(mp);
            bus(1'b1, A_CTL, 8'h01);
            u_ddpu_core_model.load(sp);
            bus(1'b1, A_CTL, c);
            ctl = c & 8'h7D;
            u_ddpu_core_model.move(k);
            if (k < 2'h2) begin
                if (ctl[0]) sp = step(sp, ctl[5:4]);
                else mp = step(mp, ctl[3:2]);
                if (ctl[6]) ctl[0] = ~ctl[0];
            end
            @(negedge ref_clk);
            chk(32'(pointer_select), 32'(ctl[0]));
            chk(32'(active_pointer), 32'(ctl[0] ? sp : mp));
            rd(A_LO, ctl[0] ? sp[7:0] : mp[7:0]);
            rd(A_HI, ctl[0] ? sp[15:8] : mp[15:8]);
            rd(A_CTL, ctl);
        end
        // Byte writes reach the active pointer; frozen clock enable drops a move
        bus(1'b1, A_CTL, 8'h04);
        bus(1'b1, A_LO, 8'h5A);
        bus(1'b1, A_HI, 8'hC3);
        @(posedge ref_clk);
        ce <= 1'b0;
        u_ddpu_core_model.move(2'h0);
        ce <= 1'b1;
        rd(A_LO, 8'h5A);
        rd(A_HI, 8'hC3);
        u_ddpu_core_model.move(2'h1);
        @(negedge ref_clk);
        chk(32'(active_pointer), 32'h0000C35B);
        // Reset in mid-run must clear pointers and control again
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk(32'(active_pointer), 32'h00000000);
        chk(32'(pointer_select), 32'h00000000);
        rd(A_CTL, 8'h00);
        rd(A_HI, 8'h00);
        summarize();
    end
endmodule // dual_data_pointer_unit_tb
